// ---- core/cmpb_defs.svh ----
`ifndef CMPB_DEFS_SVH
`define CMPB_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMPB_OFF_CTRL 12'h000
`define CMPB_OFF_MSRC 12'h004
`define CMPB_OFF_MGATE 12'h008

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define CMPB_CTRL_RST 16'h0000
`define CMPB_MSRC_RST 16'h0000
`define CMPB_MGATE_RST 16'h0000
`define CMPB_CTRL_WMASK 16'hE2D3
`define CMPB_MSRC_WMASK 16'h0FFF
`define CMPB_MGATE_WMASK 16'hBFFF

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CMPB_CTRL_EN 15
`define CMPB_CTRL_OE 14
`define CMPB_CTRL_INV 13
`define CMPB_CTRL_EVT 9
`define CMPB_CTRL_RES 8
`define CMPB_CTRL_POL_HI 7
`define CMPB_CTRL_POL_LO 6
`define CMPB_CTRL_REF 4
`define CMPB_CTRL_CH_HI 1
`define CMPB_CTRL_CH_LO 0

// ----------------------------------------------------------------
// mask source and gating field positions
// ----------------------------------------------------------------
`define CMPB_MSRC_A_LO 0
`define CMPB_MSRC_W 4
`define CMPB_MGATE_LVL 15
`define CMPB_MGATE_OR_HI 13
`define CMPB_MGATE_OR_LO 8
`define CMPB_MGATE_NAND 7
`define CMPB_MGATE_PAND 6
`define CMPB_MGATE_AND_HI 5
`define CMPB_MGATE_AND_LO 0

`endif

// ---- core/cmpb_pkg.sv ----
package cmpb_pkg;

   // event polarity modes
   typedef enum logic [1:0] {
      CMPB_EV_OFF  = 2'h0,
      CMPB_EV_RISE = 2'h1,
      CMPB_EV_FALL = 2'h2,
      CMPB_EV_ANY  = 2'h3
   } cmpb_event_polarity_sel_t;

   // mask source codes; 4'h6 to 4'hD are reserved and read low
   typedef enum logic [3:0] {
      CMPB_SRC_G1L = 4'h0,
      CMPB_SRC_G1H = 4'h1,
      CMPB_SRC_G2L = 4'h2,
      CMPB_SRC_G2H = 4'h3,
      CMPB_SRC_G3L = 4'h4,
      CMPB_SRC_G3H = 4'h5,
      CMPB_SRC_F2  = 4'hE,
      CMPB_SRC_F4  = 4'hF
   } cmpb_src_t;

   // register selected by an apb address
   typedef enum logic [1:0] {
      CMPB_REG_NONE  = 2'h0,
      CMPB_REG_CTRL  = 2'h1,
      CMPB_REG_MSRC  = 2'h2,
      CMPB_REG_MGATE = 2'h3
   } cmpb_reg_t;

endpackage

// ---- core/cmpb_mask_sel.sv ----
`timescale 1ns/1ps
module cmpb_mask_sel
   import cmpb_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // source code and candidate signals
   input wire logic [3:0] sel,
   input wire logic [5:0] pwm_src,
   input wire logic fault_two,
   input wire logic fault_four,
   // registered mask input
   output logic mask_q
);

   logic next_mask;

   // reserved codes give a quiet low rather than a stray source
   always_comb begin
      next_mask = 1'b0;
      case (cmpb_src_t'(sel))
         CMPB_SRC_G1L: next_mask = pwm_src[0];
         CMPB_SRC_G1H: next_mask = pwm_src[1];
         CMPB_SRC_G2L: next_mask = pwm_src[2];
         CMPB_SRC_G2H: next_mask = pwm_src[3];
         CMPB_SRC_G3L: next_mask = pwm_src[4];
         CMPB_SRC_G3H: next_mask = pwm_src[5];
         CMPB_SRC_F2: next_mask = fault_two;
         CMPB_SRC_F4: next_mask = fault_four;
         default: next_mask = 1'b0;
      endcase
   end

   // one flop so the blanking path sees a clean level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 1'b0;
      end else begin
         mask_q <= next_mask;
      end
   end

endmodule

// ---- core/cmpb_top.sv ----
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "cmpb_defs.svh"
module cmpb_top
   import cmpb_pkg::*;
#(
   parameter int ADDR_W = 12,
   // pins bonded out on this package; absent ones go to ground
   parameter logic POS_PIN_PRESENT = 1'b1,
   parameter logic [3:0] NEG_PIN_PRESENT = 4'hF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog comparator side
   input wire logic comparator_raw,
   output logic analog_enable,
   output logic positive_input_ref_sel,
   output logic positive_input_ground,
   output logic [1:0] negative_input_channel_sel,
   output logic negative_input_ground,
   // comparator output pin
   output logic comp_pin_out,
   output logic comp_pin_oe,
   // pwm generator outputs and fault inputs
   input wire logic gen1_low_output,
   input wire logic gen1_high_output,
   input wire logic gen2_low_output,
   input wire logic gen2_high_output,
   input wire logic gen3_low_output,
   input wire logic gen3_high_output,
   input wire logic fault_input_two,
   input wire logic fault_input_four,
   // results and events
   output logic comparator_result,
   output logic sticky_event_flag,
   output logic event_trigger,
   output logic blank_window
);

   // ----------------------------------------------------------------
   // registers and internal nets
   // ----------------------------------------------------------------
   logic [15:0] comparator4_control;
   logic [15:0] mask_source_select;
   logic [15:0] mask_gating_control;
   logic [5:0] pwm_src;
   logic [2:0] mask_in;
   logic mask_input_a;
   logic mask_input_b;
   logic mask_input_c;
   logic [5:0] mask_terms;
   logic [5:0] and_en;
   logic and_gate_output;
   logic or_gate_output;
   logic adjusted;
   logic filtered;
   logic prev_result;
   logic rise_seen;
   logic fall_seen;
   logic edge_hit;
   logic fire;
   logic wr_access;
   logic rd_setup;
   cmpb_reg_t sel_reg;
   cmpb_event_polarity_sel_t event_polarity_sel;
   logic output_invert;
   logic masking_level_sel;
   logic comp_enable;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // address decode, shared by read and write paths
   function automatic cmpb_reg_t decode(input logic [ADDR_W-1:0] a);
      cmpb_reg_t r;
      r = CMPB_REG_NONE;
      case (a)
         ADDR_W'(`CMPB_OFF_CTRL): r = CMPB_REG_CTRL;
         ADDR_W'(`CMPB_OFF_MSRC): r = CMPB_REG_MSRC;
         ADDR_W'(`CMPB_OFF_MGATE): r = CMPB_REG_MGATE;
         default: r = CMPB_REG_NONE;
      endcase
      return r;
   endfunction

   // byte-lane merge, keeping read-only and reserved bits intact
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st,
                                         input logic [15:0] wm);
      logic [15:0] lane;
      lane = {{8{st[1]}}, {8{st[0]}}} & wm;
      return (old & ~lane) | (wd[15:0] & lane);
   endfunction

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   // zero wait states: every access finishes in its first access cycle
   assign sel_reg = decode(paddr);
   assign wr_access = psel & penable & pwrite & (sel_reg != CMPB_REG_NONE);
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & (sel_reg == CMPB_REG_NONE);

   // read data captured in setup so it is steady through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (sel_reg)
            CMPB_REG_CTRL: prdata <= {16'h0000, comparator4_control};
            CMPB_REG_MSRC: prdata <= {16'h0000, mask_source_select};
            CMPB_REG_MGATE: prdata <= {16'h0000, mask_gating_control};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   // the event flag set by hardware wins over a clearing write, but
   // fire is held off while the flag is set, so an edge landing in the clear cycle is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comparator4_control <= `CMPB_CTRL_RST;
      end else begin
         if (wr_access && sel_reg == CMPB_REG_CTRL) begin
            comparator4_control <= merge(comparator4_control, pwdata,
                                         pstrb, `CMPB_CTRL_WMASK);
         end
         if (fire) begin
            comparator4_control[`CMPB_CTRL_EVT] <= 1'b1;
         end
         // result bit mirrors the blanked, polarity-adjusted output
         comparator4_control[`CMPB_CTRL_RES] <= filtered;
      end
   end

   // ----------------------------------------------------------------
   // mask source and gating registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_source_select <= `CMPB_MSRC_RST;
      end else if (wr_access && sel_reg == CMPB_REG_MSRC) begin
         mask_source_select <= merge(mask_source_select, pwdata,
                                     pstrb, `CMPB_MSRC_WMASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_gating_control <= `CMPB_MGATE_RST;
      end else if (wr_access && sel_reg == CMPB_REG_MGATE) begin
         mask_gating_control <= merge(mask_gating_control, pwdata,
                                      pstrb, `CMPB_MGATE_WMASK);
      end
   end

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   assign comp_enable = comparator4_control[`CMPB_CTRL_EN];
   assign output_invert = comparator4_control[`CMPB_CTRL_INV];
   assign event_polarity_sel = cmpb_event_polarity_sel_t'(comparator4_control[
      `CMPB_CTRL_POL_HI:`CMPB_CTRL_POL_LO]);
   assign masking_level_sel = mask_gating_control[`CMPB_MGATE_LVL];
   assign sticky_event_flag = comparator4_control[`CMPB_CTRL_EVT];
   assign comparator_result = comparator4_control[`CMPB_CTRL_RES];

   // ----------------------------------------------------------------
   // analog input routing
   // ----------------------------------------------------------------
   // selects are plain register bits; the analog mux follows them
   assign analog_enable = comp_enable;
   assign positive_input_ref_sel =
      comparator4_control[`CMPB_CTRL_REF];
   assign negative_input_channel_sel =
      comparator4_control[`CMPB_CTRL_CH_HI:`CMPB_CTRL_CH_LO];

   // a selected pin that is not bonded is grounded, never left open
   assign positive_input_ground = ~positive_input_ref_sel &
                                  ~POS_PIN_PRESENT;
   assign negative_input_ground =
      ~NEG_PIN_PRESENT[negative_input_channel_sel];

   // ----------------------------------------------------------------
   // mask input selection
   // ----------------------------------------------------------------
   assign pwm_src = {gen3_high_output, gen3_low_output,
                     gen2_high_output, gen2_low_output,
                     gen1_high_output, gen1_low_output};

   // a = bits 3-0, b = bits 7-4, c = bits 11-8
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_mask
         cmpb_mask_sel u_sel (
            .pclk(pclk),
            .presetn(presetn),
            .sel(mask_source_select[`CMPB_MSRC_A_LO + gi*`CMPB_MSRC_W
               +: `CMPB_MSRC_W]),
            .pwm_src(pwm_src),
            .fault_two(fault_input_two),
            .fault_four(fault_input_four),
            .mask_q(mask_in[gi])
         );
      end
   endgenerate

   assign mask_input_a = mask_in[0];
   assign mask_input_b = mask_in[1];
   assign mask_input_c = mask_in[2];

   // ----------------------------------------------------------------
   // blanking gates
   // ----------------------------------------------------------------
   // term order matches the enable order of both gate fields
   assign mask_terms = {mask_input_c, ~mask_input_c,
                        mask_input_b, ~mask_input_b,
                        mask_input_a, ~mask_input_a};

   // and gate over enabled terms; with none enabled it stays low
   // so an empty gate blanks everything only when the nand term is enabled
   assign and_en = mask_gating_control[
      `CMPB_MGATE_AND_HI:`CMPB_MGATE_AND_LO];
   assign and_gate_output = (|and_en) &
                            (&(~and_en | mask_terms));

   // or gate over enabled mask terms and the and gate output
   assign or_gate_output =
      (|(mask_gating_control[`CMPB_MGATE_OR_HI:`CMPB_MGATE_OR_LO]
         & mask_terms))
      | (mask_gating_control[`CMPB_MGATE_NAND] &
         ~and_gate_output)
      | (mask_gating_control[`CMPB_MGATE_PAND] &
         and_gate_output);

   assign blank_window = or_gate_output;

   // ----------------------------------------------------------------
   // output path
   // ----------------------------------------------------------------
   // polarity first, then blanking: while the window is open the
   // suppressed level is replaced by the masking_level_sel level
   assign adjusted = comparator_raw ^ output_invert;
   assign filtered = comp_enable &
      (blank_window ? masking_level_sel : adjusted);

   // output pin driven only while enabled for the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_pin_out <= 1'b0;
         comp_pin_oe <= 1'b0;
      end else begin
         comp_pin_out <= filtered;
         comp_pin_oe <= comp_enable &
                        comparator4_control[`CMPB_CTRL_OE];
      end
   end

   // ----------------------------------------------------------------
   // edge detection and events
   // ----------------------------------------------------------------
   // previous sample of the stored result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_result <= 1'b0;
      end else begin
         prev_result <= comparator_result;
      end
   end

   // edges of the polarity-adjusted, blanked output; an inverted
   // polarity turns a raw fall into a rise here and back again
   assign rise_seen = comparator_result & ~prev_result;
   assign fall_seen = ~comparator_result & prev_result;

   always_comb begin
      edge_hit = 1'b0;
      case (event_polarity_sel)
         CMPB_EV_ANY: edge_hit = rise_seen | fall_seen;
         CMPB_EV_FALL: edge_hit = fall_seen;
         CMPB_EV_RISE: edge_hit = rise_seen;
         CMPB_EV_OFF: edge_hit = 1'b0;
         default: edge_hit = 1'b0;
      endcase
   end

   // a pending flag blocks new events until software clears it;
   // that clear must come before interrupts are enabled
   assign fire = edge_hit & ~sticky_event_flag;

   // one-cycle trigger toward the interrupt and conversion logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_trigger <= 1'b0;
      end else begin
         event_trigger <= fire;
      end
   end

endmodule

// ---- bench/cmpb_properties.sv ----
`timescale 1ns/1ps
`include "cmpb_defs.svh"
module cmpb_properties #(
   parameter int ADDR_W = 12,
   parameter logic POS_PIN_PRESENT = 1'b1,
   parameter logic [3:0] NEG_PIN_PRESENT = 4'hF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   // comparator side
   input wire logic positive_input_ref_sel,
   input wire logic positive_input_ground,
   input wire logic [1:0] negative_input_channel_sel,
   input wire logic negative_input_ground,
   input wire logic comparator_result,
   input wire logic sticky_event_flag,
   input wire logic event_trigger,
   input wire logic blank_window
);
   logic wr_ok;
   logic [15:0] ctl;
   logic lvl;
   logic [1:0] pol;
   logic en;
   assign wr_ok = psel & penable & pwrite & pready;
   assign pol = ctl[7:6];
   assign en = ctl[15];
   // ----------------
   // register mirror
   // ----------------
   // only the bits that steer the event path and the input routing are trusted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= 16'h0000;
      end else if (wr_ok && paddr == ADDR_W'(`CMPB_OFF_CTRL)) begin
         if (pstrb[0]) begin
            ctl[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            ctl[15:8] <= pwdata[15:8];
         end
      end
   end
   // level select lives in the upper byte lane
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl <= 1'b0;
      end else if (wr_ok && pstrb[1]
                   && paddr == ADDR_W'(`CMPB_OFF_MGATE)) begin
         lvl <= pwdata[15];
      end
   end
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   any_edge_a: assert property (
      event_trigger && $past(pol) == 2'b11
      |-> $past(comparator_result) != $past(comparator_result, 2))
      else $error("trigger without output change");
   fall_edge_a: assert property (
      event_trigger && $past(pol) == 2'b10
      |-> !$past(comparator_result) && $past(comparator_result, 2))
      else $error("trigger without falling edge");
   rise_edge_a: assert property (
      event_trigger && $past(pol) == 2'b01
      |-> $past(comparator_result) && !$past(comparator_result, 2))
      else $error("trigger without rising edge");
   off_quiet_a: assert property (
      $past(pol) == 2'b00 |-> !event_trigger)
      else $error("trigger with events disabled");
   sticky_block_a: assert property (
      sticky_event_flag |=> !event_trigger)
      else $error("trigger while event flag set");
   trig_flag_a: assert property (
      event_trigger |-> sticky_event_flag)
      else $error("trigger without event flag");
   ref_route_a: assert property (
      positive_input_ref_sel == ctl[4])
      else $error("reference select mismatch");
   chan_route_a: assert property (
      negative_input_channel_sel == ctl[1:0])
      else $error("channel select mismatch");
   pin_ground_a: assert property (
      $stable(negative_input_channel_sel) && $stable(positive_input_ref_sel)
      |-> negative_input_ground == !NEG_PIN_PRESENT[negative_input_channel_sel]
      && positive_input_ground ==
         (!positive_input_ref_sel && !POS_PIN_PRESENT))
      else $error("absent input not grounded");
   blank_level_a: assert property (
      $past(blank_window) && $past(en) |-> comparator_result == $past(lvl))
      else $error("blanked level leaked through");
   any_cov: cover property (event_trigger && pol == 2'b11);
   blank_cov: cover property (blank_window && en);
   sticky_cov: cover property (sticky_event_flag && pol == 2'b11);
endmodule

bind cmpb_top cmpb_properties #(.ADDR_W(ADDR_W),
   .POS_PIN_PRESENT(POS_PIN_PRESENT), .NEG_PIN_PRESENT(NEG_PIN_PRESENT))
   u_prop (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .positive_input_ref_sel(positive_input_ref_sel),
   .positive_input_ground(positive_input_ground),
   .negative_input_channel_sel(negative_input_channel_sel),
   .negative_input_ground(negative_input_ground),
   .comparator_result(comparator_result),
   .sticky_event_flag(sticky_event_flag), .event_trigger(event_trigger),
   .blank_window(blank_window));

// ---- bench/cmpb_pwm_model.sv ----
`timescale 1ns/1ps
module cmpb_pwm_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire logic run,
   input wire logic [7:0] pattern,
   // generator outputs and fault inputs
   output logic gen1_low_output,
   output logic gen1_high_output,
   output logic gen2_low_output,
   output logic gen2_high_output,
   output logic gen3_low_output,
   output logic gen3_high_output,
   output logic fault_input_two,
   output logic fault_input_four
);
   logic [7:0] drv;
   // free running walk keeps every source moving while blanking is busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv <= 8'h00;
      end else if (run) begin
         drv <= {drv[6:0], ~drv[7]};
      end else begin
         drv <= pattern;
      end
   end
   assign {fault_input_four, fault_input_two, gen3_high_output,
      gen3_low_output, gen2_high_output, gen2_low_output,
      gen1_high_output, gen1_low_output} = drv;
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "cmpb_defs.svh"
module tb_top;
   localparam logic POS_P = 1'b0;
   localparam logic [3:0] NEG_P = 4'h5;
   logic pclk, presetn, psel, penable, pwrite, raw, run;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr, ref_sel, pos_gnd, neg_gnd, cres, flag, trig, blank;
   logic [1:0] ch_sel;
   logic aen, pin_o, pin_oe;
   logic g1l, g1h, g2l, g2h, g3l, g3h, f2, f4;
   logic [7:0] pattern;
   logic [32:0] rd_q[$];
   logic ev_q[$];
   int n_fail, n_compared, cycles;

   cmpb_top #(.POS_PIN_PRESENT(POS_P), .NEG_PIN_PRESENT(NEG_P)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_raw(raw), .analog_enable(aen),
      .positive_input_ref_sel(ref_sel), .positive_input_ground(pos_gnd),
      .negative_input_channel_sel(ch_sel), .negative_input_ground(neg_gnd),
      .comp_pin_out(pin_o), .comp_pin_oe(pin_oe), .gen1_low_output(g1l),
      .gen1_high_output(g1h), .gen2_low_output(g2l), .gen2_high_output(g2h),
      .gen3_low_output(g3l), .gen3_high_output(g3h), .fault_input_two(f2),
      .fault_input_four(f4), .comparator_result(cres),
      .sticky_event_flag(flag), .event_trigger(trig), .blank_window(blank));
   cmpb_pwm_model u_pwm (.pclk(pclk), .presetn(presetn), .run(run),
      .pattern(pattern), .gen1_low_output(g1l), .gen1_high_output(g1h),
      .gen2_low_output(g2l), .gen2_high_output(g2h), .gen3_low_output(g3l),
      .gen3_high_output(g3h), .fault_input_two(f2), .fault_input_four(f4));

   // ----------------
   // helpers
   // ----------------
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one apb transfer; the request stands until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      apb(1'b1, a, d, s);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask
   // reserved source codes read low
   function automatic logic pick(input logic [3:0] c, input logic [7:0] p);
      if (c < 4'h6) return p[c];
      if (c == 4'hE) return p[6];
      if (c == 4'hF) return p[7];
      return 1'b0;
   endfunction
   function automatic logic blank_exp(input logic [11:0] s,
      input logic [15:0] g, input logic [7:0] p);
      logic a, b, c, an;
      a = pick(s[3:0], p);
      b = pick(s[7:4], p);
      c = pick(s[11:8], p);
      an = |g[5:0] & (!g[5] | c) & (!g[4] | !c);
      an = an & (!g[3] | b) & (!g[2] | !b);
      an = an & (!g[1] | a) & (!g[0] | !a);
      return |({c, !c, b, !b, a, !a, !an, an} & g[13:6]);
   endfunction

   // ----------------
   // clock, watchdog and result monitor
   // ----------------
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   // results are matched against the oldest note as they appear
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (rd_q.size() == 0) begin
            check(33'h1, 33'h0);
         end else begin
            check({pslverr, prdata}, rd_q.pop_front());
         end
      end
      if (trig === 1'b1) begin
         if (ev_q.size() == 0) begin
            check(33'h1, 33'h0);
         end else begin
            check(33'(cres), 33'(ev_q.pop_front()));
         end
      end
   end

   // ----------------
   // main sequence
   // ----------------
   initial begin
      logic [15:0] cw, g;
      logic [11:0] s;
      logic [7:0] pat;
      logic bx;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, raw, run} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      pattern = 8'h00;
      void'($urandom(32'h0806));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, write masks, byte lanes, unmapped place
      rd(`CMPB_OFF_CTRL, 33'(`CMPB_CTRL_RST));
      rd(`CMPB_OFF_MSRC, 33'(`CMPB_MSRC_RST));
      rd(`CMPB_OFF_MGATE, 33'(`CMPB_MGATE_RST));
      raw <= 1'b1;
      wr(`CMPB_OFF_CTRL, 32'hFFFF, 4'hF);
      rd(`CMPB_OFF_CTRL, 33'(`CMPB_CTRL_WMASK));
      wr(`CMPB_OFF_CTRL, 32'h0, 4'h3);
      wr(`CMPB_OFF_MSRC, 32'hFFFF, 4'h3);
      rd(`CMPB_OFF_MSRC, 33'(`CMPB_MSRC_WMASK));
      wr(`CMPB_OFF_MGATE, 32'hFFFF, 4'h3);
      wr(`CMPB_OFF_MGATE, 32'h1234, 4'h2);
      rd(`CMPB_OFF_MGATE, 33'(16'h12FF & `CMPB_MGATE_WMASK));
      wr(12'h00C, 32'hFFFF, 4'hF);
      rd(12'h00C, {1'b1, 32'h0});
      wr(`CMPB_OFF_MGATE, 32'h0, 4'h3);
      // input routing for every channel and reference choice
      for (int i = 0; i < 8; i++) begin
         wr(`CMPB_OFF_CTRL, 32'(i[2]) << 4 | 32'(i[1:0]), 4'h3);
         repeat (2) @(negedge pclk);
         check(ref_sel, i[2]);
         check(ch_sel, i[1:0]);
         check(neg_gnd, !NEG_P[i[1:0]]);
         check(pos_gnd, !i[2] && !POS_P);
      end
      // every polarity mode, both output senses, flag blocking in mode 11
      for (int i = 0; i < 8; i++) begin
         raw <= i[2];
         cw = 16'h8000 | (16'(i[2]) << 13) | (16'(i[1:0]) << 6);
         wr(`CMPB_OFF_CTRL, 32'(cw), 4'h3);
         repeat (4) @(posedge pclk);
         if (i[0]) ev_q.push_back(1'b1);
         raw <= !i[2];
         repeat (4) @(posedge pclk);
         if (i[1:0] != 2'b11) wr(`CMPB_OFF_CTRL, 32'(cw), 4'h3);
         if (i[1:0] == 2'b10) ev_q.push_back(1'b0);
         raw <= i[2];
         repeat (4) @(posedge pclk);
         @(negedge pclk);
         check(flag, i[1]);
         wr(`CMPB_OFF_CTRL, 32'h0, 4'h3);
      end
      // random sources and gating, all codes on mask a
      for (int i = 0; i < 48; i++) begin
         pat = 8'($urandom);
         s = {8'($urandom), i[3:0]};
         g = 16'($urandom) & `CMPB_MGATE_WMASK;
         pattern <= pat;
         wr(`CMPB_OFF_MSRC, 32'(s), 4'h3);
         wr(`CMPB_OFF_MGATE, 32'(g), 4'h3);
         repeat (3) @(posedge pclk);
         @(negedge pclk);
         bx = blank_exp(s, g, pat);
         check(blank, bx);
      end
      // permanent window, both levels, sources moving underneath
      for (int lv = 0; lv < 2; lv++) begin
         run <= 1'b1;
         wr(`CMPB_OFF_MGATE, 32'h0300 | (32'(lv) << 15), 4'h3);
         wr(`CMPB_OFF_CTRL, 32'hC000, 4'h3);
         for (int k = 0; k < 6; k++) begin
            @(posedge pclk);
            raw <= 1'($urandom);
            @(negedge pclk);
            check(cres, lv[0]);
            check({aen, pin_oe, pin_o}, {2'b11, lv[0]});
         end
         wr(`CMPB_OFF_CTRL, 32'h0, 4'h3);
      end
      run <= 1'b0;
      repeat (4) @(posedge pclk);
      check(33'(ev_q.size()), 33'h0);
      end_sim();
   end
endmodule
